// file: hdl/src_rate_conv.sv
// Purpose: rate_conversion_routine, 16 or 8 kHz speech to 12.8 kHz
// Assumes: source on the same clock, samples far slower than the clock
// Notes: one serial multiply-accumulate, DL_LEN cycles per output sample
// Notes on behaviour
// - work in consecutive 20 ms frames
// - output rate is 12800 samples per second
// - narrow_mode picks 8 kHz or 16 kHz path
// - reset zeroes every filter delay line
// - wideband path: up by 4, filter, down 5
// - wideband cutoff 6.4 kHz at 64 kHz
// - wideband delay is 15 input samples
// - wideband filter has 121 taps
// - three zeros follow each wideband input sample
// - wideband frame holds exactly 320 input samples
// - linear phase; keep one of five samples
// - narrow path: up 8, 129 taps, down 5
// - narrow input passes first-order pole compensation
`timescale 1ns/10ps
module src_rate_conv #(
	parameter src_pkg::src_coef_t H16 = src_pkg::src_impulse(src_pkg::HALF_WB),
	parameter src_pkg::src_coef_t H8 = src_pkg::src_impulse(src_pkg::HALF_NB),
	parameter int FIFO_DEPTH = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// configuration
	input wire logic narrow_mode,
	input wire logic [15:0] input_compensation_pole,
	// input samples
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [src_pkg::SMP_W-1:0] in_data,
	// converted samples
	output logic out_valid,
	input wire logic out_ready,
	output logic [src_pkg::SMP_W-1:0] out_data,
	output logic out_last
);
	import src_pkg::*;

	if (FIFO_DEPTH < 2) begin : g_chk
		$error("src_rate_conv: FIFO_DEPTH must be at least 2");
	end

	typedef struct packed {
		src_state_e st;
		logic narrow;
		logic signed [7:0] d;
		logic [4:0] k;
		logic [5:0] mac_n;
		logic [8:0] in_cnt;
		logic [7:0] ocnt;
		logic signed [ACC_W-1:0] acc;
		logic signed [SMP_W-1:0] x1;
		logic signed [SMP_W-1:0] y1;
		logic [DL_LEN-1:0][SMP_W-1:0] dl;
	} src_state_s;

	src_state_s s_q, s_d;
	src_stream_if #(.W(SMP_W+1)) f_wr();
	src_stream_if #(.W(SMP_W+1)) f_rd();

	src_fifo #(.W(SMP_W+1), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.wr(f_wr),
		.rd(f_rd)
	);

	assign out_valid = f_rd.valid;
	assign f_rd.ready = out_ready;
	assign out_data = f_rd.data[SMP_W-1:0];
	assign out_last = f_rd.data[SMP_W];

	function automatic logic signed [SMP_W-1:0] sat16(input logic signed [ACC_W-1:0] v);
		logic signed [ACC_W-1:0] sh;
		sh = v >>> COEF_Q;
		if (sh > ACC_W'(32767)) begin
			return 16'sh7fff;
		end else if (sh < -ACC_W'(32768)) begin
			return 16'sh8000;
		end
		return sh[SMP_W-1:0];
	endfunction : sat16

	// start offset: newest position minus first output centre minus half span
	function automatic logic signed [7:0] d_init(input logic nb);
		return nb ? 8'(-(UP_NB + HALF_NB)) : 8'(-(UP_WB + HALF_WB));
	endfunction : d_init

	logic take, tap_ok, frame_wrap;
	logic [15:0] pole;
	int up, half, tt, flen;
	logic signed [SMP_W-1:0] smp, hc;
	logic signed [ACC_W-1:0] cy;

	// pole limited to the tunable span 0.5 .. 0.95
	assign pole = (input_compensation_pole < POLE_MIN) ? POLE_MIN :
		(input_compensation_pole > POLE_DEFAULT) ? POLE_DEFAULT : input_compensation_pole;

	assign in_ready = (s_q.st == ST_IDLE) && s_q.d[7];
	assign take = in_valid && in_ready;

	always_comb begin
		s_d = s_q;
		// cycles spent in the current accumulate pass, watched by a_mac_len
		s_d.mac_n = (s_q.st == ST_MAC) ? s_q.mac_n + 6'h01 : 6'h00;
		up = s_q.narrow ? UP_NB : UP_WB;
		half = s_q.narrow ? HALF_NB : HALF_WB;
		// registered mode: a pin change inside a frame must not move the frame end
		flen = s_q.narrow ? IN_FRAME_NB : IN_FRAME_WB;
		// tap index of delay entry k; skipped zero samples never reach it
		tt = int'(s_q.d) + 2 * half - up * int'(s_q.k);
		tap_ok = (tt >= 0) && (tt <= 2 * half);
		hc = s_q.narrow ? H8[tt[7:0]] : H16[tt[7:0]];
		smp = '0;
		cy = '0;
		frame_wrap = 1'b0;
		f_wr.valid = 1'b0;
		f_wr.data = {(s_q.ocnt == 8'(OUT_FRAME - 1)), sat16(s_q.acc)};
		case (s_q.st)
			ST_IDLE: begin
				if (!s_q.d[7]) begin
					s_d.st = ST_MAC;
					s_d.k = '0;
					s_d.acc = '0;
				end else if (take) begin
					// bandwidth only switches between frames, restarting the filter
					if (s_q.in_cnt == '0 && narrow_mode != s_q.narrow) begin
						s_d.narrow = narrow_mode;
						s_d.dl = '0;
						s_d.x1 = '0;
						s_d.y1 = '0;
						s_d.d = d_init(narrow_mode);
						s_d.ocnt = '0;
					end
					if (s_d.narrow) begin
						cy = (ACC_W'(signed'(in_data)) <<< COEF_Q) - (ACC_W'(s_d.x1) <<< (COEF_Q - 1))
							+ ACC_W'(signed'({1'b0, pole})) * ACC_W'(s_d.y1);
						smp = sat16(cy);
						s_d.x1 = signed'(in_data);
						s_d.y1 = smp;
					end else begin
						smp = signed'(in_data);
					end
					s_d.dl = {s_d.dl[DL_LEN-2:0], smp};
					s_d.d = s_d.d + 8'(s_d.narrow ? UP_NB : UP_WB);
					frame_wrap = (s_q.in_cnt == 9'(flen - 1));
					s_d.in_cnt = frame_wrap ? '0 : s_q.in_cnt + 1'b1;
				end
			end
			ST_MAC: begin
				if (tap_ok) begin
					s_d.acc = s_q.acc + ACC_W'(signed'(s_q.dl[s_q.k])) * ACC_W'(hc);
				end
				s_d.k = s_q.k + 1'b1;
				if (s_q.k == 5'(DL_LEN - 1)) begin
					s_d.st = ST_PUSH;
				end
			end
			ST_PUSH: begin
				f_wr.valid = 1'b1;
				if (f_wr.ready) begin
					s_d.d = s_q.d - 8'(DECIM);
					s_d.ocnt = (s_q.ocnt == 8'(OUT_FRAME - 1)) ? '0 : s_q.ocnt + 1'b1;
					s_d.st = ST_IDLE;
				end
			end
			default: begin
				s_d.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.st <= ST_IDLE;
			s_q.d <= d_init(1'b0);
		end else begin
			s_q <= s_d;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_reset_clear;
		@(posedge clk) disable iff (1'b0) !rst_n |=> (s_q.dl == '0) && (s_q.y1 == '0) && (s_q.x1 == '0);
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("filter memory not cleared by reset");

	property p_frame_len;
		take && !s_d.narrow && s_q.in_cnt == 9'(IN_FRAME_WB - 1) |=> s_q.in_cnt == '0;
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("wideband frame not 320 samples");

	property p_frame_nb;
		take && s_d.narrow && s_q.in_cnt == 9'(IN_FRAME_NB - 1) |=> s_q.in_cnt == '0;
	endproperty
	a_frame_nb: assert property (p_frame_nb) else $error("narrow frame length wrong");

	sequence s_mac_start;
		s_q.st == ST_IDLE && !s_q.d[7];
	endsequence
	sequence s_mac_end;
		s_q.st == ST_PUSH && s_q.mac_n == 6'h20;
	endsequence
	property p_mac_len;
		s_mac_start |=> (s_q.st == ST_MAC) ##32 s_mac_end;
	endproperty
	a_mac_len: assert property (p_mac_len) else $error("accumulate pass length wrong");

	property p_mac_run;
		s_q.st == ST_MAC |-> s_q.mac_n < 6'h20;
	endproperty
	a_mac_run: assert property (p_mac_run) else $error("accumulate pass runs past 32 cycles");

	property p_decim;
		f_wr.valid && f_wr.ready |=> s_q.d == $past(s_q.d) - 8'sd5;
	endproperty
	a_decim: assert property (p_decim) else $error("decimation step is not five");

	property p_interp;
		take && s_q.narrow == narrow_mode |=> s_q.d == $past(s_q.d) + (s_q.narrow ? 8'sd8 : 8'sd4);
	endproperty
	a_interp: assert property (p_interp) else $error("interpolation step wrong");

	property p_last;
		f_wr.valid && f_wr.ready && s_q.ocnt == 8'(OUT_FRAME - 1) |-> f_wr.data[SMP_W] ##1 s_q.ocnt == '0;
	endproperty
	a_last: assert property (p_last) else $error("frame end not on output 256");

	property p_wide_bypass;
		take && !narrow_mode && (s_q.in_cnt == '0 || !s_q.narrow) |=> s_q.dl[0] == $past(in_data);
	endproperty
	a_wide_bypass: assert property (p_wide_bypass) else $error("wideband sample altered on entry");

	property p_mode_hold;
		s_q.narrow != $past(s_q.narrow) |-> $past(s_q.in_cnt) == '0;
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("bandwidth changed inside a frame");
endmodule : src_rate_conv

// file: hdl/src_pkg.sv
// Purpose: shared constants and types of the speech rate converter
// Assumes: 16-bit two's complement speech samples, Q15 coefficients
// Notes: coefficient defaults are a bare centre impulse, to be replaced
package src_pkg;
	localparam int SMP_W = 16;
	localparam int ACC_W = 40;
	localparam int COEF_Q = 15;
	localparam int COEF_N = 129;
	localparam int DL_LEN = 32;
	localparam int FRAME_MS = 20;
	localparam int RATE_WB_HZ = 16000;
	localparam int RATE_NB_HZ = 8000;
	localparam int OUT_RATE_HZ = 12800;
	localparam int IN_FRAME_WB = RATE_WB_HZ * FRAME_MS / 1000;
	localparam int IN_FRAME_NB = RATE_NB_HZ * FRAME_MS / 1000;
	localparam int OUT_FRAME = OUT_RATE_HZ * FRAME_MS / 1000;
	localparam int UP_WB = 4;
	localparam int UP_NB = 8;
	localparam int DECIM = 5;
	localparam int TAPS_WB = 121;
	localparam int TAPS_NB = 129;
	localparam int HALF_WB = (TAPS_WB - 1) / 2;
	localparam int HALF_NB = (TAPS_NB - 1) / 2;
	localparam int DELAY_WB_IN = HALF_WB / UP_WB;
	localparam logic [15:0] POLE_DEFAULT = 16'h799a;
	localparam logic [15:0] POLE_MIN = 16'h4000;
	localparam logic [15:0] COEF_UNITY = 16'h7fff;

	typedef logic [COEF_N-1:0][SMP_W-1:0] src_coef_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_MAC = 3'b010,
		ST_PUSH = 3'b100
	} src_state_e;

	function automatic src_coef_t src_impulse(input int centre);
		src_coef_t c;
		c = '0;
		c[centre] = COEF_UNITY;
		return c;
	endfunction : src_impulse
endpackage : src_pkg

// file: hdl/src_stream_if.sv
// Purpose: valid/ready word stream between converter modules
// Assumes: single clock
// Notes: data is sampled when valid and ready are both high
`timescale 1ns/10ps
interface src_stream_if #(parameter int W = 17);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : src_stream_if

// file: hdl/src_fifo.sv
// Purpose: small flop-based FIFO for converted samples
// Assumes: DEPTH a power of two, at least 2
// Notes: full stalls the writer, so back-pressure reaches the filter engine
`timescale 1ns/10ps
module src_fifo #(
	parameter int W = 17,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// fill and drain sides
	src_stream_if.snk wr,
	src_stream_if.src rd
);
	import src_pkg::*;
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
		$error("src_fifo: DEPTH must be a power of two >= 2");
	end

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} src_fifo_s;

	src_fifo_s s_q, s_d;
	logic do_wr, do_rd;

	assign wr.ready = (s_q.cnt != (AW+1)'(DEPTH));
	assign rd.valid = (s_q.cnt != '0);
	assign rd.data = s_q.mem[s_q.rp];
	assign do_wr = wr.valid && wr.ready;
	assign do_rd = rd.valid && rd.ready;

	always_comb begin
		s_d = s_q;
		if (do_wr) begin
			s_d.mem[s_q.wp] = wr.data;
			s_d.wp = s_q.wp + 1'b1;
		end
		if (do_rd) begin
			s_d.rp = s_q.rp + 1'b1;
		end
		if (do_wr && !do_rd) begin
			s_d.cnt = s_q.cnt + 1'b1;
		end else if (do_rd && !do_wr) begin
			s_d.cnt = s_q.cnt - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule : src_fifo

// file: tb/src_sink_model.sv
// Purpose: consumer on the converted side, able to stall
// Assumes: same clock as the converter
// Notes: slow mode holds off 400 of 512 cycles so the FIFO fills
`timescale 1ns/10ps
module src_sink_model (
	// clock and control
	input wire logic clk,
	input wire logic slow,
	input wire logic clr,
	// converted stream
	input wire logic out_valid,
	input wire logic [15:0] out_data,
	input wire logic out_last,
	output logic out_ready
);
	logic [15:0] q_data [$];
	logic q_last [$];
	int cyc = 0;
	initial out_ready = 1'b0;
	always @(negedge clk) begin
		cyc++;
		out_ready <= !(slow && (cyc % 512) < 400);
	end
	always @(posedge clk) begin
		if (clr) begin
			q_data.delete();
			q_last.delete();
		end else if (out_valid && out_ready) begin
			q_data.push_back(out_data);
			q_last.push_back(out_last);
		end
	end
endmodule : src_sink_model

// file: tb/tb_src_rate_conv.sv
// Purpose: self-checking bench of the rate converter
// Assumes: taps at index 0 and centre, so out 4k sums x(5k) and x(5k-15)
// Notes: other phases give zero; narrow path gets one 0x1000 impulse, pole over range
`timescale 1ns/10ps
module tb_src_rate_conv;
	import src_pkg::*;
	function automatic src_coef_t mk_coef();
		src_coef_t c;
		c = '0;
		c[0] = 16'h7fff;
		c[HALF_WB] = 16'h7fff;
		return c;
	endfunction : mk_coef
	localparam src_coef_t H16_T = mk_coef();
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic narrow_mode = 1'b0;
	logic in_valid = 1'b0;
	logic slow = 1'b0;
	logic clr = 1'b0;
	logic [15:0] in_data = 16'h0000;
	logic [15:0] pole = 16'h799a;
	logic in_ready, out_valid, out_ready, out_last;
	logic [15:0] out_data;
	int err_total = 0;
	int check_count = 0;
	int taken = 0;
	int first_at = -1;
	always #25 clk = ~clk;
	always @(posedge clk) if (out_valid === 1'b1 && first_at < 0) first_at <= taken;
	src_rate_conv #(.H16(H16_T), .FIFO_DEPTH(8)) DUT (.clk(clk), .rst_n(rst_n), .narrow_mode(narrow_mode),
		.input_compensation_pole(pole), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
		.out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .out_last(out_last));
	src_sink_model SNK (.clk(clk), .slow(slow), .clr(clr), .out_valid(out_valid), .out_data(out_data),
		.out_last(out_last), .out_ready(out_ready));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic final_report();
		$display("checks=%0d mismatches=%0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report
	function automatic int xr(input int k);
		return (k * 7) % 4000 + 1;
	endfunction : xr
	task automatic restart(input logic rst);
		rst_n = !rst;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		clr = 1'b1;
		@(negedge clk);
		clr = 1'b0;
		taken = 0;
		first_at = -1;
	endtask : restart
	// any sample count, each sample held until taken
	task automatic send(input logic [15:0] x);
		int w;
		w = 0;
		in_valid = 1'b1;
		in_data = x;
		while (in_ready !== 1'b1 && w < 4000) begin
			@(negedge clk);
			w++;
		end
		if (w >= 4000) begin
			err_total++;
			final_report();
		end else begin
			@(negedge clk);
			taken++;
		end
	endtask : send
	task automatic wait_out(input int n);
		int w;
		w = 0;
		in_valid = 1'b0;
		while (SNK.q_data.size() < n && w < 30000) begin
			@(negedge clk);
			w++;
		end
		if (w >= 30000) begin
			err_total++;
			final_report();
		end
		repeat (300) @(negedge clk);
		chk(16'(SNK.q_data.size()), 16'(n));
	endtask : wait_out
	task automatic check_wide(input int nin);
		int n, m, a;
		n = 0;
		// output n needs input ceil(5n/4) + 15 in hand
		while ((5 * n + 3) / 4 + 15 <= nin - 1) n++;
		wait_out(n);
		chk(16'(first_at), 16'd16);
		for (int i = 0; i < n; i++) begin
			m = (5 * i) / 4;
			a = (i % 4 == 0) ? xr(m) + ((m >= 15) ? xr(m - 15) : 0) - 1 : 0;
			chk(SNK.q_data[i], 16'(a));
			chk({15'h0000, SNK.q_last[i]}, {15'h0000, i % 256 == 255});
		end
	endtask : check_wide
	task automatic t_wide();
		slow = 1'b1;
		restart(1'b1);
		for (int k = 0; k < 960; k++) send(16'(xr(k)));
		check_wide(960);
		slow = 1'b0;
		$display("test wide done");
	endtask : t_wide
	task automatic t_narrow();
		int n, a;
		int y [320];
		restart(1'b0);
		narrow_mode = 1'b1;
		// above the tunable span, so the pole must clamp to 0.95
		pole = 16'hffff;
		// compensation y = x - x1/2 + 0.95 y1 in Q15 for a lone 0x1000 at sample 0
		for (int k = 0; k < 320; k++) begin
			y[k] = (k == 0) ? 4096 : (int'(POLE_DEFAULT) * y[k - 1] - ((k == 1) ? 4096 * 16384 : 0)) >>> 15;
		end
		for (int k = 0; k < 320; k++) send((k == 0) ? 16'h1000 : 16'h0000);
		n = 0;
		// output n needs input ceil(5n/8) + 8 in hand
		while ((5 * n + 7) / 8 + 8 <= 319) n++;
		wait_out(n);
		chk(16'(first_at), 16'd9);
		for (int i = 0; i < n; i++) begin
			a = (i % 8 == 0) ? (y[(5 * i) / 8] * 32767) >>> 15 : 0;
			chk(SNK.q_data[i], 16'(a));
			chk({15'h0000, SNK.q_last[i]}, {15'h0000, i % 256 == 255});
		end
		$display("test narrow done");
	endtask : t_narrow
	task automatic t_reset();
		for (int k = 0; k < 50; k++) send(16'h1234);
		in_valid = 1'b0;
		narrow_mode = 1'b0;
		restart(1'b1);
		for (int k = 0; k < 320; k++) send(16'(xr(k)));
		check_wide(320);
		$display("test reset done");
	endtask : t_reset
	initial begin
		t_wide();
		t_narrow();
		t_reset();
		final_report();
	end
endmodule : tb_src_rate_conv
